/* File: hw/acs_pkg.sv */
// constants, states and carriers of the adc conversion sequencer
`default_nettype none
package acs_pkg;
  localparam int RES_W  = 10;
  localparam int CHAN_W = 4;
  localparam int SEL_W  = 3;
  localparam int DIV_W  = 7;
  localparam int PER_W  = 4;
  // conversion clock select codes
  localparam logic [SEL_W-1:0] SEL_DIV2  = 3'h0;
  localparam logic [SEL_W-1:0] SEL_DIV4  = 3'h4;
  localparam logic [SEL_W-1:0] SEL_DIV8  = 3'h1;
  localparam logic [SEL_W-1:0] SEL_DIV16 = 3'h5;
  localparam logic [SEL_W-1:0] SEL_DIV32 = 3'h2;
  localparam logic [SEL_W-1:0] SEL_DIV64 = 3'h6;
  localparam logic [1:0]       SEL_FRC   = 2'h3; // low two bits, top bit ignored
  // system clocks per bit period for each divider
  localparam logic [DIV_W-1:0] DIV2  = 7'h02;
  localparam logic [DIV_W-1:0] DIV4  = 7'h04;
  localparam logic [DIV_W-1:0] DIV8  = 7'h08;
  localparam logic [DIV_W-1:0] DIV16 = 7'h10;
  localparam logic [DIV_W-1:0] DIV32 = 7'h20;
  localparam logic [DIV_W-1:0] DIV64 = 7'h40;
  localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;
  // bit period counts
  localparam logic [PER_W-1:0] LAST_PERIOD     = 4'ha; // eleventh period, index 10
  localparam logic [PER_W-1:0] FIRST_BIT_PER   = 4'h1;
  localparam logic [PER_W-1:0] RECOVER_PERIODS = 4'h2;
  localparam logic [PER_W-1:0] PER_ONE         = 4'h1;
  localparam logic [PER_W-1:0] PER_ZERO        = 4'h0;
  // one instruction cycle in system clocks
  localparam logic [PER_W-1:0] INSTR_CLKS = 4'h4;
  // format select
  localparam logic JUSTIFY_RIGHT = 1'b1;
  localparam logic [RES_W-1:0] MSB_TRIAL = 10'h200;
  localparam logic [RES_W-1:0] RES_ZERO  = 10'h000;
  localparam logic [7:0]       BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV, ST_RECOVER} acs_state_e;

  typedef struct packed {
    logic              converter_on;
    logic              result_justify_select;
    logic [CHAN_W-1:0] channel_select;
    logic [SEL_W-1:0]  conv_clock_select;
    logic              conversion_irq_enable;
  } acs_ctrl_s;

  typedef struct packed {
    logic go_done;
    logic conversion_done_flag;
    logic irq;
    logic wake;
    logic powered;
    logic sampling;
    logic timer_reset;
  } acs_stat_s;

  typedef struct packed {
    logic [7:0] result_high;
    logic [7:0] result_low;
  } acs_result_s;
endpackage
`default_nettype wire

/* File: hw/acs_sequencer.sv */
// adc conversion sequencer: clock select, sar stepping, abort, sleep and result
//////////////////////////////////////////////////////////////////////////////
// Contract
// - conversion clock is sysclk/2..64 by three-bit select, x11 picks internal oscillator.
// - a conversion takes eleven bit periods, one result bit in each of the last ten.
// - converter runs only while on; writing go starts a conversion.
// - completion clears go, sets done flag and loads the result pair.
// - done flag is set on every completion regardless of interrupt enable.
// - hardware never clears the done flag; software clears it.
// - with enable set, completion raises interrupt, and in sleep wakes the device.
// - result is left or right justified by the format bit.
// - clearing go early aborts and keeps the previous result.
// - after abort wait two bit periods, then acquisition resumes on selected channel.
// - reset returns everything to reset state and stops any conversion.
// - with internal oscillator, start waits one extra instruction cycle.
// - conversion continues in sleep only on the internal oscillator.
// - oscillator sleep, interrupt off: power down after completion, on bit stays.
// - sleep on another clock aborts and powers down, on bit stays.
// - special trigger sets go and resets the trigger timer counter.
// - selected channel is routed to the sample and hold input.
// - result registers are read only; no write path exists.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer (
  input  wire logic                     mclk_i,
  input  wire logic                     rst_i,
  input  wire acs_pkg::acs_ctrl_s       ctrl_i,
  input  wire logic                     go_set_i,
  input  wire logic                     go_clear_i,
  input  wire logic                     flag_clear_i,
  input  wire logic                     trigger_i,
  input  wire logic                     sleep_i,
  input  wire logic                     frc_tick_i,
  input  wire logic                     compare_i,
  output wire acs_pkg::acs_stat_s       stat_o,
  output var  acs_pkg::acs_result_s     result_o,
  output var  logic [acs_pkg::RES_W-1:0]  trial_code_o,
  output var  logic [acs_pkg::CHAN_W-1:0] channel_o
);
  import acs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [DIV_W-1:0] div_ratio(input logic [SEL_W-1:0] sel);
    case (sel)
      SEL_DIV2:  div_ratio = DIV2;
      SEL_DIV4:  div_ratio = DIV4;
      SEL_DIV8:  div_ratio = DIV8;
      SEL_DIV16: div_ratio = DIV16;
      SEL_DIV32: div_ratio = DIV32;
      SEL_DIV64: div_ratio = DIV64;
      default:   div_ratio = DIV2;
    endcase
  endfunction

  function automatic acs_result_s fmt_result(input logic [RES_W-1:0] code, input logic right);
    acs_result_s r;
    r = '0;
    if (right) begin
      r.result_high = {6'h00, code[9:8]};
      r.result_low  = code[7:0];
    end else begin
      r.result_high = code[9:2];
      r.result_low  = {code[1:0], 6'h00};
    end
    fmt_result = r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state
  acs_state_e        state;
  logic              go_done;
  logic              flag;
  logic              irq;
  logic              wake;
  logic              powered;
  logic              pwr_down;
  logic              sampling;
  logic              timer_reset;
  logic [DIV_W-1:0]  div_cnt;
  logic [PER_W-1:0]  period;
  logic [PER_W-1:0]  dly_cnt;
  logic              frc_sel;
  logic              tad_tick;
  logic              sleep_abort;
  logic              set_req;
  logic              start_ok;
  logic              done_evt;
  logic [PER_W-1:0]  bit_idx;
  logic [RES_W-1:0]  next_code;

  assign stat_o = '{go_done:              go_done,
                    conversion_done_flag: flag,
                    irq:                  irq,
                    wake:                 wake,
                    powered:              powered,
                    sampling:             sampling,
                    timer_reset:          timer_reset};

  // clock source and event decode
  // x11 selects the oscillator
  assign frc_sel     = (ctrl_i.conv_clock_select[1:0] == SEL_FRC);
  // sleep on a divided clock kills the conversion
  assign sleep_abort = sleep_i && !frc_sel;
  assign set_req     = (go_set_i || trigger_i) && ctrl_i.converter_on && !sleep_abort;
  assign start_ok    = go_done && powered && ctrl_i.converter_on && !sleep_abort;
  assign bit_idx     = LAST_PERIOD - period;
  assign done_evt    = (state == ST_CONV) && tad_tick && (period == LAST_PERIOD)
                       && go_done && ctrl_i.converter_on && !sleep_abort;

  // resolve current bit from comparator, msb first
  always_comb begin
    next_code = trial_code_o;
    next_code[bit_idx[3:0]] = compare_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit period divider
  // count clocks per bit period, restart on abort
  always_ff @(posedge mclk_i) begin
    if (rst_i || !(state == ST_CONV || state == ST_RECOVER) || tad_tick || (state == ST_CONV && !go_done)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_ONE;
    end
  end

  assign tad_tick = frc_sel ? frc_tick_i
                            : (div_cnt == div_ratio(ctrl_i.conv_clock_select) - DIV_ONE);

  //////////////////////////////////////////////////////////////////////////////
  // go/done bit
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      go_done <= 1'b0;
    // converter off drops go; sleep abort drops it too
    end else if (!ctrl_i.converter_on || sleep_abort) begin
      go_done <= 1'b0;
    // set wins over completion and software clear
    end else if (set_req) begin
      go_done <= 1'b1;
    end else if (done_evt || go_clear_i) begin
      go_done <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state   <= ST_IDLE;
      period  <= PER_ZERO;
      dly_cnt <= PER_ZERO;
    end else begin
      case (state)
        ST_IDLE: begin
          period  <= PER_ZERO;
          dly_cnt <= PER_ZERO;
          if (start_ok) begin
            // oscillator source waits one instruction cycle
            state <= frc_sel ? ST_DELAY : ST_CONV;
          end
        end
        ST_DELAY: begin
          dly_cnt <= dly_cnt + PER_ONE;
          if (!ctrl_i.converter_on || sleep_abort) begin
            state <= ST_IDLE;
          end else if (!go_done) begin
            state <= ST_RECOVER;
          end else if (dly_cnt == INSTR_CLKS - PER_ONE) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          // sleep on a divided clock or power off ends the conversion outright
          if (!ctrl_i.converter_on || sleep_abort) begin
            state <= ST_IDLE;
          end else if (!go_done) begin
            state  <= ST_RECOVER;
            period <= PER_ZERO;
          end else if (tad_tick) begin
            if (period == LAST_PERIOD) begin
              state <= ST_IDLE;
            end
            period <= period + PER_ONE;
          end
        end
        ST_RECOVER: begin
          // hold two bit periods before acquiring again
          if (!ctrl_i.converter_on || sleep_abort) begin
            state <= ST_IDLE;
          end else if (tad_tick) begin
            if (period == RECOVER_PERIODS - PER_ONE) begin
              state <= ST_IDLE;
            end
            period <= period + PER_ONE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // successive approximation trial code
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      trial_code_o <= RES_ZERO;
    end else if (state == ST_IDLE && start_ok) begin
      trial_code_o <= MSB_TRIAL;
    // bit 9 in period two through bit 0 in period eleven
    end else if (state == ST_CONV && tad_tick && period >= FIRST_BIT_PER && go_done) begin
      trial_code_o <= next_code;
      if (bit_idx != PER_ZERO) begin
        trial_code_o[bit_idx[3:0] - 4'h1] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // result pair read only, no write path
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      result_o <= '0;
    // load on completion; justify per format bit
    end else if (done_evt) begin
      result_o <= fmt_result(next_code, ctrl_i.result_justify_select);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // done flag and interrupt
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flag <= 1'b0;
    // set on every completion; set wins over clear
    end else if (done_evt) begin
      flag <= 1'b1;
    end else if (flag_clear_i) begin
      flag <= 1'b0;
    end
  end

  // level request and sleep wake pulse
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq  <= 1'b0;
      wake <= 1'b0;
    end else begin
      irq  <= flag && ctrl_i.conversion_irq_enable;
      wake <= sleep_i && done_evt && ctrl_i.conversion_irq_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power, channel, acquisition and trigger side effects
  always_ff @(posedge mclk_i) begin
    if (rst_i || !sleep_i) begin
      pwr_down <= 1'b0;
    // divided clock in sleep powers down
    end else if (sleep_abort) begin
      pwr_down <= 1'b1;
    // oscillator sleep with interrupt off powers down after completion
    end else if (done_evt && !ctrl_i.conversion_irq_enable) begin
      pwr_down <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      powered     <= 1'b0;
      sampling    <= 1'b0;
      timer_reset <= 1'b0;
      channel_o   <= '0;
    end else begin
      // analog block enabled only while on
      powered     <= ctrl_i.converter_on && !pwr_down && !sleep_abort;
      // acquisition runs while idle and powered with no start pending
      sampling    <= powered && state == ST_IDLE && !start_ok;
      // trigger resets the trigger timer counter
      timer_reset <= trigger_i && ctrl_i.converter_on;
      // route selected channel to sample and hold
      channel_o   <= ctrl_i.channel_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_go_clear_on_done;
    done_evt && !set_req |=> !go_done;
  endproperty
  a_go_clear_on_done: assert property (p_go_clear_on_done) else $error("go not cleared at completion");

  property p_flag_set;
    done_evt |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not set");

  property p_flag_sticky;
    flag && !flag_clear_i |=> flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("done flag cleared by hardware");

  property p_abort_keeps_result;
    state == ST_RECOVER |=> $stable(result_o);
  endproperty
  a_abort_keeps_result: assert property (p_abort_keeps_result) else $error("result changed after abort");

  property p_period_steps;
    state == ST_CONV && tad_tick && go_done && ctrl_i.converter_on && !sleep_abort
      && period != LAST_PERIOD |=> period == $past(period) + PER_ONE;
  endproperty
  a_period_steps: assert property (p_period_steps) else $error("bit period count slipped");

  property p_off_no_go;
    !ctrl_i.converter_on |=> !go_done && state != ST_CONV;
  endproperty
  a_off_no_go: assert property (p_off_no_go) else $error("converting while off");

  property p_frc_delay;
    state == ST_IDLE && start_ok && frc_sel |=> (state != ST_CONV)[*4];
  endproperty
  a_frc_delay: assert property (p_frc_delay) else $error("oscillator start not delayed");

  property p_sleep_abort;
    sleep_i && !frc_sel |=> !go_done && state != ST_CONV ##1 !powered;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");

  property p_right_justify;
    done_evt && ctrl_i.result_justify_select == JUSTIFY_RIGHT |=> result_o.result_high[7:2] == 6'h00;
  endproperty
  a_right_justify: assert property (p_right_justify) else $error("right justify upper bits set");

  property p_irq;
    flag && ctrl_i.conversion_irq_enable |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_trigger;
    trigger_i && ctrl_i.converter_on && !sleep_abort |=> go_done && timer_reset;
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger did not set go");

  c_done:    cover property (done_evt);
  c_abort:   cover property (state == ST_CONV ##1 state == ST_RECOVER);
  c_sleep:   cover property (sleep_i && frc_sel && done_evt);
  c_trigger: cover property (trigger_i && ctrl_i.converter_on);
endmodule
`default_nettype wire

/* File: sim/acs_far_side.sv */
// far side model: analog comparator and free running internal oscillator
`timescale 1ns/1ps
`default_nettype none
module acs_far_side #(
  parameter int FRC_P = 6
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  input  wire logic [acs_pkg::RES_W-1:0] trial_code_i,
  input  wire logic [acs_pkg::RES_W-1:0] analog_i,
  output var  logic                      compare_o,
  output var  logic                      frc_tick_o
);
  import acs_pkg::*;
  int cnt;
  // input at or above the trial code keeps the bit
  always_comb compare_o = (analog_i >= trial_code_i);
  // oscillator runs free, one tick per bit period
  always_ff @(posedge mclk_i) begin
    if (rst_i || cnt >= FRC_P - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
    frc_tick_o <= !rst_i && (cnt == FRC_P - 1);
  end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// scoreboard testbench of the adc conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acs_pkg::*;
  localparam int FRC_P = 6;
  logic              mclk_i, rst_i, go_set_i, go_clear_i, flag_clear_i;
  logic              trigger_i, sleep_i, frc_tick_i, compare_i, flag_d;
  acs_ctrl_s         ctrl_i;
  acs_stat_s         stat_o;
  acs_result_s       result_o, exp_r, held;
  logic [RES_W-1:0]  trial_code_o, analog;
  logic [CHAN_W-1:0] channel_o;
  acs_result_s       exp_q[$];
  int                err_count, comparisons, cycles, wake_cnt, trig_cnt, n;
  int                seed = 28;
  logic [SEL_W-1:0]  sels [8] = '{SEL_DIV2, SEL_DIV4, SEL_DIV8, SEL_DIV16, SEL_DIV32, SEL_DIV64, 3'h3, 3'h7};
  int                pers [8] = '{2, 4, 8, 16, 32, 64, FRC_P, FRC_P};

  acs_sequencer acs_sequencer_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ctrl_i(ctrl_i), .go_set_i(go_set_i),
    .go_clear_i(go_clear_i), .flag_clear_i(flag_clear_i), .trigger_i(trigger_i), .sleep_i(sleep_i),
    .frc_tick_i(frc_tick_i), .compare_i(compare_i), .stat_o(stat_o), .result_o(result_o),
    .trial_code_o(trial_code_o), .channel_o(channel_o));
  acs_far_side #(.FRC_P(FRC_P)) acs_far_side_inst (.mclk_i(mclk_i), .rst_i(rst_i), .trial_code_i(trial_code_o),
    .analog_i(analog), .compare_o(compare_i), .frc_tick_o(frc_tick_i));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    comparisons++;
    if (seen !== expv) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic tick(input int k = 1);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  // one conversion, started by software or by the trigger
  task automatic convert(input logic [SEL_W-1:0] sel, input logic just, input int per, input logic slp,
                         input logic trig);
    int m;
    int wk;
    int tr;
    analog = RES_W'($random(seed));
    ctrl_i.conv_clock_select = sel;
    ctrl_i.result_justify_select = just;
    ctrl_i.channel_select = analog[CHAN_W-1:0];
    flag_clear_i = 1'b1;
    tick();
    flag_clear_i = 1'b0;
    wk = wake_cnt;
    tr = trig_cnt;
    exp_q.push_back(just === JUSTIFY_RIGHT ? {6'h00, analog} : {analog, 6'h00});
    go_set_i = !trig;
    trigger_i = trig;
    tick();
    go_set_i = 1'b0;
    trigger_i = 1'b0;
    sleep_i = slp;
    tick();
    check("go_done", 16'(stat_o.go_done), 16'h1);
    check("channel", 16'(channel_o), 16'(ctrl_i.channel_select));
    check("trial start", 16'(trial_code_o), 16'(MSB_TRIAL));
    m = 0;
    while (stat_o.go_done !== 1'b0 && m < 2000) begin
      tick();
      m++;
    end
    check("bit periods", 16'(m >= 10 * per && m <= 12 * per + 12), 16'h1);
    tick(2);
    check("flag", 16'(stat_o.conversion_done_flag), 16'h1);
    check("irq", 16'(stat_o.irq), 16'(ctrl_i.conversion_irq_enable));
    check("wake", 16'(wake_cnt - wk), 16'(slp & ctrl_i.conversion_irq_enable));
    check("timer reset", 16'(trig_cnt - tr), 16'(trig));
    if (slp && !ctrl_i.conversion_irq_enable) check("powered", 16'(stat_o.powered), 16'h0);
    tick(20);
    check("flag held", 16'(stat_o.conversion_done_flag), 16'h1);
    sleep_i = 1'b0;
    tick();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang limit
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      give_verdict();
    end
  end
  // monitor: a rising done flag takes the oldest note
  always @(posedge mclk_i) begin
    flag_d <= stat_o.conversion_done_flag;
    if (stat_o.wake === 1'b1) wake_cnt++;
    if (stat_o.timer_reset === 1'b1) trig_cnt++;
    if (stat_o.conversion_done_flag === 1'b1 && flag_d === 1'b0) begin
      if (exp_q.size() == 0) begin
        check("unexpected result", 16'h1, 16'h0);
      end else begin
        exp_r = exp_q.pop_front();
        check("result pair", result_o, exp_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, go_set_i, go_clear_i, flag_clear_i, trigger_i, sleep_i} = 6'h20;
    ctrl_i = '0;
    analog = '0;
    tick(8);
    check("stat in reset", 16'(stat_o), 16'h0);
    check("result in reset", result_o, 16'h0);
    rst_i = 1'b0;
    go_set_i = 1'b1;
    tick();
    go_set_i = 1'b0;
    tick(3);
    check("go while off", 16'(stat_o.go_done), 16'h0);
    ctrl_i.converter_on = 1'b1;
    tick(2);
    for (int i = 0; i < 8; i++) begin
      ctrl_i.conversion_irq_enable = i[0];
      convert(sels[i], i[1], pers[i], 1'b0, 1'b0);
    end
    convert(3'h3, 1'b1, FRC_P, 1'b1, 1'b0);
    ctrl_i.conversion_irq_enable = 1'b0;
    convert(3'h7, 1'b0, FRC_P, 1'b1, 1'b0);
    convert(SEL_DIV4, 1'b0, 4, 1'b0, 1'b1);
    // abort in mid conversion, then recovery
    held = result_o;
    ctrl_i.conv_clock_select = SEL_DIV8;
    flag_clear_i = 1'b1;
    tick();
    flag_clear_i = 1'b0;
    go_set_i = 1'b1;
    tick();
    go_set_i = 1'b0;
    tick(30);
    go_clear_i = 1'b1;
    tick();
    go_clear_i = 1'b0;
    tick(2);
    check("go after abort", 16'(stat_o.go_done), 16'h0);
    check("result after abort", result_o, held);
    n = 0;
    while (stat_o.sampling !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    check("recovery span", 16'(n >= 2 * 8 && n <= 2 * 8 + 2), 16'h1);
    // sleep on a divided clock aborts
    go_set_i = 1'b1;
    tick();
    go_set_i = 1'b0;
    tick(20);
    sleep_i = 1'b1;
    tick(3);
    check("go in sleep", 16'(stat_o.go_done), 16'h0);
    check("powered in sleep", 16'(stat_o.powered), 16'h0);
    check("result in sleep", result_o, held);
    sleep_i = 1'b0;
    tick(40);
    check("flag after aborts", 16'(stat_o.conversion_done_flag), 16'h0);
    // reset in mid conversion
    go_set_i = 1'b1;
    tick();
    go_set_i = 1'b0;
    tick(10);
    rst_i = 1'b1;
    tick();
    check("stat mid reset", 16'(stat_o), 16'h0);
    check("result mid reset", result_o, 16'h0);
    rst_i = 1'b0;
    tick(120);
    check("pending notes", 16'(exp_q.size()), 16'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
